/* hw/pps_power_ctrl.sv */
// Power-setting decode, source setpoint clamp and power-off sequencer.
// Assumes command/data bytes arrive as one-cycle strobes on ref_clk_i;
// the stream is produced by on-chip logic so no synchroniser is needed.
`timescale 1ns/1ps
module pps_power_ctrl
  import pps_pkg::*;
#(
  parameter int SHUTDOWN_CYC  = pps_pkg::PPS_SHUTDOWN_CYC,
  parameter int DISCHARGE_CYC = pps_pkg::PPS_DISCHARGE_CYC
)(
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       srst_i,
  // Byte stream from the serial command interface
  input  wire logic       byte_valid_i,
  input  wire logic       command_data_select_i,
  input  wire logic [7:0] byte_data_i,
  // Idle state of source and common outputs, from earlier configuration
  input  wire logic       idle_float_i,
  // Decoded setpoints, magnitudes in 100 mV units
  output logic            source_mode1_o,
  output logic [1:0]      gate_level_select_o,
  output logic [7:0]      source_pos_o,
  output logic [7:0]      source_neg_o,
  output logic [7:0]      source_low_o,
  // Power-off sequencing
  output logic            busy_indicator_n_o,
  output logic            analog_enable_o,
  output logic            discharge_o,
  output logic            idle_float_o
);
  import pps_pkg::*;

  pps_cmd_e   cmd_reg;
  logic [2:0] pidx_reg;
  logic       mode1_reg;
  logic [1:0] gate_reg;
  logic [6:0] low0_reg, pos1_reg, neg1_reg, low1_reg;
  logic [7:0] pof_reg;
  pps_off_e   st_reg;
  logic [31:0] cnt_reg;
  logic [7:0] pos_reg, neg_reg, low_reg;

  wire cmd_strobe   = byte_valid_i && !command_data_select_i;
  wire param_strobe = byte_valid_i && command_data_select_i;
  wire pof_cmd      = cmd_strobe && (byte_data_i == PPS_CMD_POWER_OFF);
  wire pof_start    = pof_cmd && (st_reg == PPS_IDLE);
  wire pof_param    = param_strobe && (cmd_reg == PPS_P_POF) && (pidx_reg == 3'h0);
  wire pwr_param    = param_strobe && (cmd_reg == PPS_P_PWR);

  // Magnitudes: code plus 30 gives the 100 mV value
  wire [7:0] pos1_mag = {1'b0, pos1_reg} + 8'h1e;
  wire [7:0] low0_mag = {1'b0, low0_reg} + 8'h1e;
  wire [7:0] low1_mag = {1'b0, low1_reg} + 8'h1e;
  // Negative codes beyond the table saturate; the last negative entry is ambiguous
  wire [7:0] neg1_mag = ({1'b0, neg1_reg} > PPS_NEG_LEVEL_MAX) ?
                        PPS_NEG_LEVEL_MAX + 8'h1e : {1'b0, neg1_reg} + 8'h1e;
  wire [7:0] pos_raw = mode1_reg ? pos1_mag : PPS_FIXED_15V;
  wire [7:0] neg_raw = mode1_reg ? neg1_mag : PPS_FIXED_15V;
  wire [7:0] low_raw = mode1_reg ? low1_mag : low0_mag;
  wire [7:0] limit   = (gate_reg == PPS_GATE_15V) ? PPS_LIMIT_15V :
                       (gate_reg == PPS_GATE_10V) ? PPS_LIMIT_10V : PPS_NO_LIMIT;
  wire [7:0] pos_cl  = (pos_raw > limit) ? limit : pos_raw;
  wire [7:0] neg_cl  = (neg_raw > limit) ? limit : neg_raw;
  wire [7:0] low_cl  = (low_raw > limit) ? limit : low_raw;
  wire       cnt_done = (cnt_reg == 32'h0);

  // Command tracking and parameter index
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      cmd_reg  <= PPS_P_NONE;
      pidx_reg <= 3'h0;
    end
    else if (cmd_strobe)
    begin
      pidx_reg <= 3'h0;
      if (byte_data_i == PPS_CMD_POWER_SETTING)
        cmd_reg <= PPS_P_PWR;
      else if (pof_start)
        cmd_reg <= PPS_P_POF;
      else
        cmd_reg <= PPS_P_NONE;
    end
    else if (param_strobe && pidx_reg != PPS_PWR_NPARAM)
      pidx_reg <= pidx_reg + 3'h1;
  end

  // Power-setting parameter capture; registers survive power-off
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      mode1_reg <= PPS_PWR_P1_RST[PPS_MODE_BIT];
      gate_reg  <= PPS_GATE_RST;
      low0_reg  <= PPS_LEVEL_RST;
      pos1_reg  <= PPS_LEVEL_RST;
      neg1_reg  <= PPS_LEVEL_RST;
      low1_reg  <= PPS_LEVEL_RST;
    end
    else if (pwr_param)
    begin
      case (pidx_reg)
        3'h0: mode1_reg <= byte_data_i[PPS_MODE_BIT];
        3'h1: gate_reg  <= byte_data_i[PPS_GATE_LSB +: 2];
        3'h2: low0_reg  <= byte_data_i[6:0];
        3'h3: pos1_reg  <= byte_data_i[6:0];
        3'h4: neg1_reg  <= byte_data_i[6:0];
        3'h5: low1_reg  <= byte_data_i[6:0];
        default: ;
      endcase
    end
  end

  // Power-off parameter; discharge decision is taken when the shutdown phase ends
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      pof_reg <= PPS_POF_RST;
    else if (pof_param)
      pof_reg <= byte_data_i;
  end

  // Power-off sequence
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      st_reg  <= PPS_IDLE;
      cnt_reg <= 32'h0;
    end
    else
    begin
      case (st_reg)
        PPS_IDLE:
          if (pof_start)
          begin
            st_reg  <= PPS_SHUTDOWN;
            cnt_reg <= 32'(SHUTDOWN_CYC - 1);
          end
        PPS_SHUTDOWN:
          if (!cnt_done)
            cnt_reg <= cnt_reg - 32'h1;
          else if (pof_reg[PPS_DISCH_BIT])
          begin
            st_reg  <= PPS_DISCHARGE;
            cnt_reg <= 32'(DISCHARGE_CYC - 1);
          end
          else
            st_reg <= PPS_IDLE;
        PPS_DISCHARGE:
          if (!cnt_done)
            cnt_reg <= cnt_reg - 32'h1;
          else
            st_reg <= PPS_IDLE;
        default: st_reg <= PPS_IDLE;
      endcase
    end
  end

  // Analog enable latches off after the first power-off; power-on is elsewhere
  logic analog_reg;
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      analog_reg <= 1'b1;
      pos_reg    <= 8'h0;
      neg_reg    <= 8'h0;
      low_reg    <= 8'h0;
    end
    else
    begin
      if (pof_start)
        analog_reg <= 1'b0;
      pos_reg <= pos_cl;
      neg_reg <= neg_cl;
      low_reg <= low_cl;
    end
  end

  assign source_mode1_o      = mode1_reg;
  assign gate_level_select_o = gate_reg;
  assign source_pos_o        = pos_reg;
  assign source_neg_o        = neg_reg;
  assign source_low_o        = low_reg;
  assign busy_indicator_n_o  = (st_reg == PPS_IDLE);
  assign analog_enable_o     = analog_reg;
  assign discharge_o         = (st_reg == PPS_DISCHARGE);
  assign idle_float_o        = idle_float_i;

  // Power-off walk: accepted command, shutdown end, optional discharge phase
  sequence pof_accept_s;
    pof_start;
  endsequence
  sequence shutdown_end_s;
    (st_reg == PPS_SHUTDOWN) && cnt_done && pof_reg[PPS_DISCH_BIT];
  endsequence
  sequence discharge_on_s;
    discharge_o && !busy_indicator_n_o;
  endsequence

  busy_on_start_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    pof_accept_s |=> !busy_indicator_n_o) else $error("busy not low after power-off");
  no_start_busy_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (!busy_indicator_n_o && pof_cmd) |-> !pof_start ##1 (cmd_reg == PPS_P_NONE))
    else $error("power-off accepted while busy");
  analog_off_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    pof_accept_s |=> !analog_enable_o) else $error("analog still on");
  disch_gate_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    $rose(discharge_o) |-> pof_reg[0]) else $error("discharge without enable");
  disch_step_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    shutdown_end_s |=> discharge_on_s) else $error("discharge phase not entered");
  clamp_ten_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    gate_reg == PPS_GATE_10V |=> source_pos_o <= 8'h50) else $error("clamp missed");
  mode0_fixed_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (!mode1_reg && gate_reg == PPS_GATE_20V) |=> source_neg_o == PPS_FIXED_15V)
    else $error("mode0 rail wrong");
  mode_bit_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (pwr_param && pidx_reg == 3'h0) |=> mode1_reg == $past(byte_data_i[PPS_MODE_BIT]))
    else $error("mode bit not taken");
  gate_field_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (pwr_param && pidx_reg == 3'h1) |=> gate_reg == $past(byte_data_i[1:0]))
    else $error("gate field not taken");
  pos_code_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (mode1_reg && gate_reg == PPS_GATE_20V) |=> source_pos_o == 8'($past(pos1_reg)) + 8'h1e)
    else $error("positive code map wrong");
  neg_code_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (mode1_reg && gate_reg == PPS_GATE_20V) |=> source_neg_o <= 8'h6e)
    else $error("negative code beyond -11 V");
endmodule

/* hw/pps_pkg.sv */
// Constants for the panel power-setting decode and power-off sequencer.
// Assumes a byte-wide command/parameter stream already deserialised.
package pps_pkg;
  localparam logic [7:0] PPS_CMD_POWER_SETTING = 8'h01;
  localparam logic [7:0] PPS_CMD_POWER_OFF     = 8'h02;
  // Power-setting and power-off parameter field positions
  localparam int PPS_MODE_BIT   = 3;
  localparam int PPS_GATE_LSB   = 0;
  localparam int PPS_DISCH_BIT  = 0;
  // Parameter byte count of the power-setting command
  localparam logic [2:0] PPS_PWR_NPARAM = 3'h6;
  // Reset values
  localparam logic [7:0] PPS_PWR_P1_RST  = 8'h07;
  localparam logic [1:0] PPS_GATE_RST    = 2'h0;
  localparam logic [6:0] PPS_LEVEL_RST   = 7'h00;
  localparam logic [7:0] PPS_POF_RST     = 8'h00;
  // Level codes are in 100 mV steps above 3 V magnitude
  localparam logic [7:0] PPS_LEVEL_MAX     = 8'h51;
  localparam logic [7:0] PPS_NEG_LEVEL_MAX = 8'h50;
  localparam logic [7:0] PPS_FIXED_15V     = 8'h96;
  // Source setpoints in 100 mV, clamp limits for the 15 V and 10 V gate levels (gate minus 2 V)
  localparam logic [7:0] PPS_LIMIT_15V = 8'h82;
  localparam logic [7:0] PPS_LIMIT_10V = 8'h50;
  localparam logic [7:0] PPS_NO_LIMIT  = 8'hff;
  localparam logic [1:0] PPS_GATE_20V = 2'h0;
  localparam logic [1:0] PPS_GATE_17V = 2'h1;
  localparam logic [1:0] PPS_GATE_15V = 2'h2;
  localparam logic [1:0] PPS_GATE_10V = 2'h3;
  // Power-off sequence timing
  localparam int PPS_CLK_HZ        = 20000000;
  localparam int PPS_SHUTDOWN_US   = 100;
  localparam int PPS_DISCHARGE_US  = 100;
  localparam int PPS_SHUTDOWN_CYC  = PPS_SHUTDOWN_US * (PPS_CLK_HZ / 1000000);
  localparam int PPS_DISCHARGE_CYC = PPS_DISCHARGE_US * (PPS_CLK_HZ / 1000000);
  typedef enum logic [1:0] {PPS_IDLE, PPS_SHUTDOWN, PPS_DISCHARGE} pps_off_e;
  typedef enum logic [1:0] {PPS_P_NONE, PPS_P_PWR, PPS_P_POF} pps_cmd_e;
endpackage

/* test/pps_host_model.sv */
// Host-side byte source for the power controller.
// Assumes the bench clock; drives only just after falling edges.
`timescale 1ns/1ps
module pps_host_model (
  // Clock and device status
  input  wire logic       ref_clk_i,
  input  wire logic       busy_indicator_n_i,
  // Byte stream towards the device
  output logic            byte_valid_o,
  output logic            command_data_select_o,
  output logic [7:0]      byte_data_o
);
  initial
  begin
    byte_valid_o = 1'b0;
    command_data_select_o = 1'b0;
    byte_data_o = 8'h00;
  end

  // Always leaves one idle cycle, so valid is never driven twice in one step
  task automatic send_byte(input logic dcx, input logic [7:0] data);
    @(negedge ref_clk_i);
    byte_valid_o = 1'b1;
    command_data_select_o = dcx;
    byte_data_o = data;
    @(negedge ref_clk_i);
    byte_valid_o = 1'b0;
    // Released bus shows the inverse, not a stale byte
    byte_data_o = ~data;
  endtask

  // Polls for up to 200 cycles until busy is high again; send_byte does not wait on it
  task automatic wait_ready(output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 200 && !ok; i++)
    begin
      @(negedge ref_clk_i);
      ok = (busy_indicator_n_i === 1'b1);
    end
  endtask
endmodule

/* test/tb.sv */
// Self-checking bench for the power-setting decode and power-off sequencer.
// Assumes pps_pkg and the host byte model are compiled first.
`timescale 1ns/1ps
module tb;
  import pps_pkg::*;
  localparam int SD = 8;
  localparam int DC = 8;
  logic       ref_clk_i, srst_i, idle_float_i, bv, dcx, mode1, busy_n, an_en, disch, flt;
  logic [7:0] bd, pos, neg, low;
  logic [1:0] gate;
  int         n_fail, cmp_count, seed, ep, en, el, em, eg;
  int         prm_q[$];
  bit         ok;

  pps_power_ctrl #(.SHUTDOWN_CYC(SD), .DISCHARGE_CYC(DC)) pps_power_ctrl_inst (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .byte_valid_i(bv),
    .command_data_select_i(dcx), .byte_data_i(bd), .idle_float_i(idle_float_i),
    .source_mode1_o(mode1), .gate_level_select_o(gate), .source_pos_o(pos),
    .source_neg_o(neg), .source_low_o(low), .busy_indicator_n_o(busy_n),
    .analog_enable_o(an_en), .discharge_o(disch), .idle_float_o(flt));
  pps_host_model pps_host_model_inst (
    .ref_clk_i(ref_clk_i), .busy_indicator_n_i(busy_n),
    .byte_valid_o(bv), .command_data_select_o(dcx), .byte_data_o(bd));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  function automatic int clampv(int v, int g);
    int lim;
    lim = (g == 2) ? 130 : (g == 3) ? 80 : 255;
    return (v > lim) ? lim : v;
  endfunction

  // Reference model: queue holds mode byte, gate byte, then four level codes
  task automatic model_and_check();
    em = prm_q[0][3];
    eg = prm_q[1] & 3;
    ep = clampv(em ? 30 + prm_q[3] : 150, eg);
    en = clampv(em ? 30 + ((prm_q[4] > 80) ? 80 : prm_q[4]) : 150, eg);
    el = clampv(30 + (em ? prm_q[5] : prm_q[2]), eg);
    chk("mode", 8'(em), {7'h0, mode1});
    chk("gate", 8'(eg), {6'h0, gate});
    chk("pos", 8'(ep), pos);
    chk("neg", 8'(en), neg);
    chk("low", 8'(el), low);
  endtask

  task automatic power_off(input logic dis, input bit dup);
    int n;
    bit seen;
    n = 0;
    seen = 1'b0;
    idle_float_i = 1'($random(seed));
    pps_host_model_inst.send_byte(1'b0, PPS_CMD_POWER_OFF);
    fork
      begin
        pps_host_model_inst.send_byte(1'b1, {7'h0, dis});
        if (dup)
        begin
          pps_host_model_inst.send_byte(1'b0, PPS_CMD_POWER_OFF);
          pps_host_model_inst.send_byte(1'b1, 8'h01);
        end
      end
      while (busy_n === 1'b0 && n < 100)
      begin
        n++;
        seen |= (disch === 1'b1);
        @(negedge ref_clk_i);
      end
    join
    chk("busy_len", 8'(SD + (dis ? DC : 0)), 8'(n));
    chk("discharge", {7'h0, dis}, {7'h0, seen});
    chk("analog_en", 8'h00, {7'h0, an_en});
    chk("idle_float", {7'h0, idle_float_i}, {7'h0, flt});
    model_and_check();
    pps_host_model_inst.wait_ready(ok);
    chk("ready", 8'h01, {7'h0, ok});
    if (!ok)
      complete_run();
  endtask

  initial
  begin
    seed = 32'h961c;
    n_fail = 0;
    cmp_count = 0;
    srst_i = 1'b1;
    idle_float_i = 1'b0;
    prm_q = {7, 0, 0, 0, 0, 0};
    repeat (8) @(negedge ref_clk_i);
    srst_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    chk("busy_rst", 8'h01, {7'h0, busy_n});
    chk("an_rst", 8'h01, {7'h0, an_en});
    model_and_check();
    for (int i = 0; i < 8; i++)
    begin
      prm_q = {7 | ((i & 1) << 3), i >> 1, {$random(seed)} % 82, 0, {$random(seed)} % 128};
      prm_q.push_back({$random(seed)} % 82);
      prm_q[3] = prm_q[5] + {$random(seed)} % (82 - prm_q[5]);
      pps_host_model_inst.send_byte(1'b0, PPS_CMD_POWER_SETTING);
      foreach (prm_q[k])
        pps_host_model_inst.send_byte(1'b1, 8'(prm_q[k]));
      repeat (3) @(negedge ref_clk_i);
      model_and_check();
    end
    power_off(1'b0, 1'b0);
    power_off(1'b1, 1'b0);
    power_off(1'b0, 1'b1);
    srst_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    srst_i = 1'b0;
    prm_q = {7, 0, 0, 0, 0, 0};
    repeat (2) @(negedge ref_clk_i);
    chk("an_rst2", 8'h01, {7'h0, an_en});
    chk("busy_rst2", 8'h01, {7'h0, busy_n});
    model_and_check();
    complete_run();
  end
endmodule
